// file: rtl/uoec_pkg.sv
// Package: register map, field positions and sizes of the OUT endpoint block
package uoec_pkg;
  // Printed offset 0x15 is not a multiple of four: offsets kept as indices
  localparam logic [7:0]  UOEC_IDX_CTRL_LOW  = 8'h14;
  localparam logic [7:0]  UOEC_IDX_CTRL_HIGH = 8'h15;
  localparam logic [7:0]  UOEC_IDX_PKT_IN    = 8'h16;
  localparam logic [7:0]  UOEC_IDX_FIFO_DATA = 8'h17;
  localparam logic [11:0] UOEC_ADDR_CTRL_LOW  = 12'h050;
  localparam logic [11:0] UOEC_ADDR_CTRL_HIGH = 12'h054;
  localparam logic [11:0] UOEC_ADDR_PKT_IN    = 12'h058;
  localparam logic [11:0] UOEC_ADDR_FIFO_DATA = 12'h05c;

  // Low control byte fields
  localparam int UOEC_BIT_RDY    = 0;
  localparam int UOEC_BIT_FULL   = 1;
  localparam int UOEC_BIT_LOST   = 2;
  localparam int UOEC_BIT_DERR   = 3;
  localparam int UOEC_BIT_FLUSH  = 4;
  localparam int UOEC_BIT_STALL  = 5;
  // High control byte fields
  localparam int UOEC_BIT_ISO    = 6;
  localparam int UOEC_BIT_DBUF   = 7;

  localparam logic [7:0] UOEC_CTRL_LOW_RST  = 8'h00;
  localparam logic [7:0] UOEC_CTRL_HIGH_RST = 8'h00;

  localparam int UOEC_PKT_WORDS  = 16;
  localparam int UOEC_PKT_SLOTS  = 2;

  // Handshake codes returned to the host side
  localparam logic [1:0] UOEC_HS_NONE  = 2'h0;
  localparam logic [1:0] UOEC_HS_ACK   = 2'h1;
  localparam logic [1:0] UOEC_HS_NAK   = 2'h2;
  localparam logic [1:0] UOEC_HS_STALL = 2'h3;
endpackage : uoec_pkg

// file: rtl/uoec_flag.sv
`timescale 1ns/100ps
// Sticky flag: hardware set wins over software clear
module uoec_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);
  logic flag_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
  assign flag = flag_q;
endmodule : uoec_flag

// file: rtl/uoec_pkt_fifo.sv
`timescale 1ns/100ps
// Packet FIFO: up to two packets of fixed depth, word read port
module uoec_pkt_fifo #(
  parameter int WIDTH = 8,
  parameter int WORDS = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_last,
  input  wire logic             rd_en,
  input  wire logic             pop_pkt,
  output logic [WIDTH-1:0]      rd_data,
  output logic [1:0]            pkt_cnt,
  output logic                  rd_started
);
  localparam int AW = $clog2(WORDS);
  logic [WIDTH-1:0] mem [2][WORDS];
  logic             wsel_q;
  logic             rsel_q;
  logic [AW-1:0]    wptr_q;
  logic [AW-1:0]    rptr_q;
  logic [1:0]       cnt_q;
  logic [WIDTH-1:0] rd_q;

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wsel_q][wptr_q] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wsel_q <= 1'b0;
      wptr_q <= '0;
    end else if (wr_en && wr_last) begin
      wsel_q <= ~wsel_q;
      wptr_q <= '0;
    end else if (wr_en) begin
      wptr_q <= wptr_q + AW'(1);
    end
  end

  // Popping a packet resets the read pointer to the next slot start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsel_q <= 1'b0;
      rptr_q <= '0;
      rd_q   <= '0;
    end else if (pop_pkt) begin
      rsel_q <= ~rsel_q;
      rptr_q <= '0;
    end else if (rd_en) begin
      rd_q   <= mem[rsel_q][rptr_q];
      rptr_q <= rptr_q + AW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'd0;
    end else begin
      cnt_q <= cnt_q + 2'(wr_en && wr_last) - 2'(pop_pkt);
    end
  end

  assign rd_data    = rd_q;
  assign pkt_cnt    = cnt_q;
  assign rd_started = (rptr_q != '0);
endmodule : uoec_pkt_fifo

// file: rtl/uoec_ctrl.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
// OUT endpoint control: APB registers, stall, flush, flags, packet FIFO
// Notes on behaviour
// - Clearing send-stall resumes normal OUT answers
// - Isochronous mode ignores send-stall
// - Flush write discards only oldest packet
// - Flush resets read pointer, clears packet ready unless a second packet remains
// - Flush bit self-clears when flush done
// - Packet into full FIFO sets lost flag, except in bulk mode with send-stall set
// - Full flag from packet count and buffering
// - Bit 7 selects single or double buffering
// - Bit 6 selects bulk or isochronous
// - Send-stall set stalls every bulk OUT request
// - Complete packet sets ready, raises event when no packet is waiting
// - ISO CRC-error packet stored, flags error
module uoec_ctrl
  import uoec_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int WORDS  = UOEC_PKT_WORDS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              out_token,
  input  wire logic              rx_valid,
  input  wire logic [DATA_W-1:0] rx_data,
  input  wire logic              rx_last,
  input  wire logic              rx_crc_err,
  output logic [1:0]             handshake,
  output logic                   handshake_valid,
  output logic                   pkt_ready_event
);
  logic        stall_q;
  logic        iso_q;
  logic        dbuf_q;
  logic        flush_q;
  logic        rdy_q;
  logic        rdy_set;
  logic        rdy_clr;
  logic        lost_flag;
  logic        derr_flag;
  logic        full;
  logic        busy_q;
  logic        drop_q;
  logic        crc_seen_q;
  logic [1:0]  pkt_cnt;
  logic        rd_started;
  logic [DATA_W-1:0] fifo_rd;
  logic [1:0]  hs_q;
  logic        hs_v_q;
  logic        evt_q;
  logic [31:0] rdata_q;
  logic        wr_acc;
  logic        rd_acc;
  logic        wr_low;
  logic        wr_high;
  logic        rd_fifo;
  logic        pop;
  logic        pkt_done;
  logic        accept;
  logic        stall_eff;

  // Aligned word address decode
  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] ref_a);
    return a == ref_a;
  endfunction : addr_is

  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign wr_low  = wr_acc && pstrb[0] && addr_is(paddr, UOEC_ADDR_CTRL_LOW);
  assign wr_high = wr_acc && pstrb[0] && addr_is(paddr, UOEC_ADDR_CTRL_HIGH);
  assign rd_fifo = rd_acc && addr_is(paddr, UOEC_ADDR_FIFO_DATA)
                   && (pkt_cnt != 2'd0) && !flush_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable
                   && !addr_is(paddr, UOEC_ADDR_CTRL_LOW)
                   && !addr_is(paddr, UOEC_ADDR_CTRL_HIGH)
                   && !addr_is(paddr, UOEC_ADDR_PKT_IN)
                   && !addr_is(paddr, UOEC_ADDR_FIFO_DATA);

  // Buffering and transfer type
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbuf_q <= UOEC_CTRL_HIGH_RST[UOEC_BIT_DBUF];
      iso_q  <= UOEC_CTRL_HIGH_RST[UOEC_BIT_ISO];
    end else if (wr_high) begin
      dbuf_q <= pwdata[UOEC_BIT_DBUF];
      iso_q  <= pwdata[UOEC_BIT_ISO];
    end
  end

  // Send-stall control bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_q <= UOEC_CTRL_LOW_RST[UOEC_BIT_STALL];
    end else if (wr_low) begin
      stall_q <= pwdata[UOEC_BIT_STALL];
    end
  end

  assign stall_eff = stall_q && !iso_q;

  // Flush: one packet per write, bit self-clears next cycle
  assign pop = flush_q && (pkt_cnt != 2'd0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_q <= 1'b0;
    end else if (flush_q) begin
      flush_q <= 1'b0;
    end else if (wr_low && pwdata[UOEC_BIT_FLUSH]) begin
      flush_q <= 1'b1;
    end
  end

  // Full flag from packet count and buffering mode
  assign full = dbuf_q ? (pkt_cnt >= 2'd2) : (pkt_cnt >= 2'd1);

  // Receive path: accept or drop a whole packet at its first word
  assign accept   = rx_valid && !busy_q && !drop_q && !full && !stall_eff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q     <= 1'b0;
      drop_q     <= 1'b0;
      crc_seen_q <= 1'b0;
    end else if (rx_valid && rx_last) begin
      busy_q     <= 1'b0;
      drop_q     <= 1'b0;
      crc_seen_q <= 1'b0;
    end else if (rx_valid) begin
      busy_q     <= busy_q || accept;
      drop_q     <= drop_q || (!busy_q && !accept);
      crc_seen_q <= crc_seen_q || rx_crc_err;
    end
  end

  logic store;
  assign store    = rx_valid && (busy_q || accept);
  assign pkt_done = store && rx_last
                    && (iso_q || !(crc_seen_q || rx_crc_err));

  uoec_pkt_fifo #(
    .WIDTH (DATA_W),
    .WORDS (WORDS)
  ) u_fifo (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_en      (store),
    .wr_data    (rx_data),
    .wr_last    (rx_last && pkt_done),
    .rd_en      (rd_fifo),
    .pop_pkt    (pop || (rdy_clr && rdy_q && !flush_q)),
    .rd_data    (fifo_rd),
    .pkt_cnt    (pkt_cnt),
    .rd_started (rd_started)
  );

  // Packet ready: set on a complete packet or re-raised for a queued one
  assign rdy_clr = wr_low && !pwdata[UOEC_BIT_RDY];
  always_comb begin
    rdy_set = pkt_done && (pkt_cnt == 2'd0 || rdy_clr);
    if (rdy_clr && rdy_q && pkt_cnt == 2'd2) begin
      rdy_set = 1'b1;
    end
    if (pop && pkt_cnt == 2'd2) begin
      rdy_set = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
    end else if (rdy_set) begin
      rdy_q <= 1'b1;
    end else if (pop || rdy_clr) begin
      rdy_q <= 1'b0;
    end
  end

  // Sticky error flags, cleared only by writing zero
  uoec_flag u_lost (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (rx_valid && !busy_q && !drop_q && full
              && !stall_eff),
    .clr     (wr_low && !pwdata[UOEC_BIT_LOST]),
    .flag    (lost_flag)
  );

  uoec_flag u_derr (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (pkt_done && iso_q
              && (crc_seen_q || rx_crc_err)),
    .clr     (wr_low && !pwdata[UOEC_BIT_DERR]),
    .flag    (derr_flag)
  );

  // Handshake answer to each bulk OUT token
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_q   <= UOEC_HS_NONE;
      hs_v_q <= 1'b0;
    end else if (out_token) begin
      hs_v_q <= !iso_q;
      if (stall_eff) begin
        hs_q <= UOEC_HS_STALL;
      end else if (full) begin
        hs_q <= UOEC_HS_NAK;
      end else begin
        hs_q <= UOEC_HS_ACK;
      end
    end else begin
      hs_v_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= rdy_set;
    end
  end

  // Read data mux
  always_comb begin
    rdata_q = 32'h0000_0000;
    if (addr_is(paddr, UOEC_ADDR_CTRL_LOW)) begin
      rdata_q[UOEC_BIT_RDY]   = rdy_q;
      rdata_q[UOEC_BIT_FULL]  = full;
      rdata_q[UOEC_BIT_LOST]  = lost_flag;
      rdata_q[UOEC_BIT_DERR]  = derr_flag;
      rdata_q[UOEC_BIT_FLUSH] = flush_q;
      rdata_q[UOEC_BIT_STALL] = stall_q;
    end else if (addr_is(paddr, UOEC_ADDR_CTRL_HIGH)) begin
      rdata_q[UOEC_BIT_DBUF] = dbuf_q;
      rdata_q[UOEC_BIT_ISO]  = iso_q;
    end else if (addr_is(paddr, UOEC_ADDR_PKT_IN)) begin
      rdata_q[1:0] = pkt_cnt;
      rdata_q[2]   = rd_started;
    end
  end

  // Read data comes straight from register fields; FIFO word one read later
  assign prdata = addr_is(paddr, UOEC_ADDR_FIFO_DATA)
                  ? {{(32-DATA_W){1'b0}}, fifo_rd} : rdata_q;

  assign handshake       = hs_q;
  assign handshake_valid = hs_v_q;
  assign pkt_ready_event = evt_q;
endmodule : uoec_ctrl

// file: dv/uoec_ctrl_properties.sv
// Checker: port-level properties of the OUT endpoint control block
`timescale 1ns/100ps
module uoec_ctrl_properties
  import uoec_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        out_token,
  input wire logic [1:0]  handshake,
  input wire logic        handshake_valid,
  input wire logic        pkt_ready_event
);
  logic stall_q;
  logic iso_q;
  logic wr_c;
  logic mapped;
  assign wr_c = psel && penable && pwrite && pstrb[0];
  assign mapped = paddr inside {UOEC_ADDR_CTRL_LOW, UOEC_ADDR_CTRL_HIGH,
                                UOEC_ADDR_PKT_IN, UOEC_ADDR_FIFO_DATA};
  // Shadow of the stall and isochronous bits as written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_q <= 1'b0;
      iso_q   <= 1'b0;
    end else if (wr_c && paddr == UOEC_ADDR_CTRL_LOW) begin
      stall_q <= pwdata[UOEC_BIT_STALL];
    end else if (wr_c && paddr == UOEC_ADDR_CTRL_HIGH) begin
      iso_q <= pwdata[UOEC_BIT_ISO];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_bulk_tok;
    out_token && !iso_q;
  endsequence
  sequence s_stall_hs;
    handshake_valid && handshake == UOEC_HS_STALL;
  endsequence
  stall_hs_a: assert property (
    s_bulk_tok ##0 stall_q |=> s_stall_hs) else $error("no stall answer");
  resume_hs_a: assert property (
    s_bulk_tok ##0 !stall_q |=> handshake_valid
    && handshake != UOEC_HS_STALL)
    else $error("bad answer without stall");
  iso_quiet_a: assert property (
    out_token && iso_q |=> !handshake_valid) else $error("iso answered");
  hs_cause_a: assert property (
    handshake_valid |-> $past(out_token)) else $error("answer w/o token");
  hs_pulse_a: assert property (
    handshake_valid |=> !handshake_valid) else $error("answer too long");
  ready_pulse_a: assert property (
    $rose(pkt_ready_event) |=> !pkt_ready_event) else $error("event long");
  bad_addr_a: assert property (
    psel && penable && !mapped |-> pslverr) else $error("no slverr");
  good_addr_a: assert property (
    psel && penable && mapped |-> !pslverr && pready) else $error("slverr");
endmodule : uoec_ctrl_properties

bind uoec_ctrl uoec_ctrl_properties u_uoec_ctrl_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .out_token(out_token),
  .handshake(handshake), .handshake_valid(handshake_valid),
  .pkt_ready_event(pkt_ready_event));

// file: dv/uoec_host_model.sv
// Host model: sends OUT tokens and data packets
`timescale 1ns/100ps
module uoec_host_model (
  input  wire logic pclk,
  output logic       out_token,
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rx_last,
  output logic       rx_crc_err
);
  initial begin
    out_token  = 1'b0;
    rx_valid   = 1'b0;
    rx_data    = 8'h00;
    rx_last    = 1'b0;
    rx_crc_err = 1'b0;
  end
  // Called just after a rising edge; one token, then n data words
  task automatic send(input int n, input logic [7:0] base,
                      input logic err);
    out_token <= 1'b1;
    @(posedge pclk);
    out_token <= 1'b0;
    for (int i = 0; i < n; i++) begin
      rx_valid   <= 1'b1;
      rx_data    <= base + i[7:0];
      rx_last    <= (i == n - 1);
      rx_crc_err <= err;
      @(posedge pclk);
    end
    rx_valid   <= 1'b0;
    rx_last    <= 1'b0;
    rx_crc_err <= 1'b0;
    // Idle data line does not keep the last word
    rx_data    <= ~rx_data;
    @(posedge pclk);
  endtask : send
endmodule : uoec_host_model

// file: dv/uoec_ctrl_tb.sv
// Testbench: APB sequences against the OUT endpoint control block
`timescale 1ns/100ps
module uoec_ctrl_tb
  import uoec_pkg::*;
;
  localparam logic [11:0] L = UOEC_ADDR_CTRL_LOW;
  localparam logic [11:0] H = UOEC_ADDR_CTRL_HIGH;
  localparam logic [11:0] S = UOEC_ADDR_PKT_IN;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic out_token, rx_valid, rx_last, rx_crc_err, handshake_valid;
  logic pkt_ready_event;
  logic [7:0]  rx_data;
  logic [1:0]  handshake;
  int bad_count;
  int checked;
  int evt_count;
  uoec_ctrl u_uoec_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_token(out_token), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_crc_err(rx_crc_err), .handshake(handshake),
    .handshake_valid(handshake_valid), .pkt_ready_event(pkt_ready_event));
  uoec_host_model u_uoec_host_model (.pclk(pclk), .out_token(out_token),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_crc_err(rx_crc_err));
  // Counts packet-ready event pulses seen at the block's port
  always @(posedge pclk) begin
    if (!presetn) begin
      evt_count <= 0;
    end else if (pkt_ready_event) begin
      evt_count <= evt_count + 1;
    end
  end
  task automatic conclude();
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      conclude();
    end
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic chk(input logic [11:0] a, input logic [7:0] exp);
    apb(a, 1'b0, 32'h0);
    cmp(r[7:0], exp);
  endtask : chk
  // First read only primes the word pipeline
  task automatic drain(input logic [7:0] base);
    apb(UOEC_ADDR_FIFO_DATA, 1'b0, 32'h0);
    for (int i = 0; i < UOEC_PKT_WORDS; i++) begin
      chk(UOEC_ADDR_FIFO_DATA, base + i[7:0]);
    end
  endtask : drain
  task automatic pkt(input logic [7:0] base, input logic err);
    u_uoec_host_model.send(UOEC_PKT_WORDS, base, err);
  endtask : pkt
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    bad_count = 0;
    checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(L, 8'h00);
    chk(H, 8'h00);
    apb(12'h0f0, 1'b0, 32'h0);
    pkt(8'h10, 1'b0);
    chk(L, 8'h03);
    cmp(evt_count[7:0], 8'h01);
    pkt(8'h40, 1'b0);
    chk(L, 8'h07);
    apb(L, 1'b1, 32'h01);
    chk(L, 8'h03);
    apb(L, 1'b1, 32'h05);
    chk(L, 8'h03);
    chk(S, 8'h01);
    drain(8'h10);
    apb(L, 1'b1, 32'h00);
    chk(L, 8'h00);
    apb(H, 1'b1, 32'h80);
    chk(H, 8'h80);
    pkt(8'h20, 1'b0);
    chk(L, 8'h01);
    pkt(8'h30, 1'b0);
    chk(L, 8'h03);
    apb(L, 1'b1, 32'h00);
    chk(L, 8'h01);
    cmp(evt_count[7:0], 8'h03);
    drain(8'h30);
    apb(L, 1'b1, 32'h00);
    pkt(8'h50, 1'b0);
    pkt(8'h60, 1'b0);
    apb(L, 1'b1, 32'h11);
    chk(S, 8'h01);
    apb(L, 1'b0, 32'h0);
    cmp(r[7:0] & 8'h12, 8'h00);
    drain(8'h60);
    apb(L, 1'b1, 32'h00);
    pkt(8'h70, 1'b0);
    pkt(8'h78, 1'b0);
    apb(L, 1'b1, 32'h11);
    apb(L, 1'b1, 32'h11);
    chk(S, 8'h00);
    chk(L, 8'h00);
    apb(L, 1'b1, 32'h20);
    pkt(8'h80, 1'b0);
    chk(S, 8'h00);
    apb(L, 1'b1, 32'h00);
    pkt(8'h90, 1'b0);
    chk(S, 8'h01);
    apb(L, 1'b1, 32'h00);
    apb(H, 1'b1, 32'hc0);
    chk(H, 8'hc0);
    apb(L, 1'b1, 32'h20);
    pkt(8'ha0, 1'b1);
    chk(L, 8'h29);
    apb(L, 1'b1, 32'h21);
    chk(L, 8'h21);
    drain(8'ha0);
    conclude();
  end
endmodule : uoec_ctrl_tb
